// ### hw/wdg_pkg.sv
package wdg_pkg;
  // ****************************************
  // Register map.
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CLR = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CNT = 8'h10;
  // ****************************************
  // Field layout and reset values.
  // ****************************************
  localparam int CFG_SEL_BIT = 0;
  localparam int CFG_PER_LO = 1;
  localparam int CFG_PER_HI = 2;
  localparam int CFG_LOCK_BIT = 3;
  localparam int STAT_TMO_BIT = 0;
  localparam logic [7:0] CLEAR_CODE = 8'h4e;
  localparam logic SEL_RST = 1'b1;
  localparam int PER_W = 2;
  localparam logic [1:0] PER_RST = 2'h3;
  localparam logic [1:0] MASK_RST = 2'h0;
  // ****************************************
  // Counter geometry and timing.
  // ****************************************
  localparam int DIV_W = 20;
  localparam int BIN_W = 2;
  localparam logic [1:0] BIN_TOP = 2'h3;
  localparam int TAP_BASE = 12;
  localparam int TAP_STEP = 2;
  localparam int RST_PULSE_CYC = 16;
  localparam logic [4:0] RST_PULSE = 5'h10;
  typedef logic [PER_W-1:0] wdg_per_t;
  typedef enum logic {WDG_RUN, WDG_RESET} wdg_state_t;
endpackage

// ### hw/wdg_if.sv
`timescale 1ns/1ps
interface wdg_if;
  import wdg_pkg::*;
  logic hold;
  logic clear;
  logic reinit;
  wdg_per_t per;
  logic ovf;
  logic [BIN_W-1:0] count;
  modport ctl(output hold, output clear, output reinit, output per, input ovf, input count);
  modport cnt(input hold, input clear, input reinit, input per, output ovf, output count);
endinterface

// ### hw/wdg_counter.sv
`timescale 1ns/1ps
module wdg_counter (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control from the register side.
  wdg_if.cnt ctl
);
  import wdg_pkg::*;
  logic [DIV_W-1:0] div;
  logic [BIN_W-1:0] bin;
  logic ovf;
  logic [DIV_W-1:0] next_div;
  logic [BIN_W-1:0] next_bin;
  logic next_ovf;
  logic [DIV_W-1:0] tap_mask;
  logic tick;
  // ****************************************
  // Divider, tap select and binary counter.
  // ****************************************
  always_comb begin
    tap_mask = DIV_W'((1 << (TAP_BASE + TAP_STEP * int'(ctl.per))) - 1);
    tick = !ctl.hold && ((div & tap_mask) == tap_mask);
    next_div = div;
    next_bin = bin;
    next_ovf = 1'b0;
    if (ctl.reinit) begin
      next_div = '0;
      next_bin = '0;
    end else if (!ctl.hold) begin
      next_div = div + 1'b1;
      if (ctl.clear) begin
        next_bin = '0;
      end else if (tick) begin
        next_bin = bin + 1'b1;
        next_ovf = (bin == BIN_TOP);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
      bin <= '0;
      ovf <= 1'b0;
    end else begin
      div <= next_div;
      bin <= next_bin;
      ovf <= next_ovf;
    end
  end
  assign ctl.ovf = ovf;
  assign ctl.count = bin;
  // ****************************************
  // Checks.
  // ****************************************
  property p_hold;
    @(posedge pclk) disable iff (!presetn) (ctl.hold && !ctl.reinit) |=> $stable(div) && $stable(bin);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while held");
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (ctl.clear && !ctl.hold && !ctl.reinit) |=> bin == '0 && div == $past(div) + 1'b1;
  endproperty
  a_clear: assert property (p_clear) else $error("clear touched divider or missed counter");
  property p_ovf;
    @(posedge pclk) disable iff (!presetn) ovf |-> $past(bin) == BIN_TOP && bin == '0;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without counter wrap");
  property p_auto;
    @(posedge pclk) disable iff (!presetn) (!ctl.hold && !ctl.reinit) |=> div != $past(div);
  endproperty
  a_auto: assert property (p_auto) else $error("divider not running");
  property p_tap;
    @(posedge pclk) disable iff (!presetn)
      (bin != $past(bin) && !$past(ctl.clear) && !$past(ctl.reinit)) |-> $past(tick);
  endproperty
  a_tap: assert property (p_tap) else $error("counter stepped off the tap");
endmodule

// ### hw/wdg_top.sv
`timescale 1ns/1ps
module wdg_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Low-power mode indication.
  input wire logic low_power_hold,
  // Watchdog outputs.
  output logic rst_pin_n,
  output logic guard_timeout_irq,
  output logic irq
);
  import wdg_pkg::*;
  wdg_if wif ();
  wdg_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(wif.cnt)
  );
  wdg_state_t state;
  wdg_state_t next_state;
  logic timeout_action_select;
  logic next_timeout_action_select;
  logic sel_locked;
  logic next_sel_locked;
  wdg_per_t detection_period_select;
  wdg_per_t next_detection_period_select;
  logic [1:0] stat;
  logic [1:0] next_stat;
  logic [1:0] mask;
  logic [1:0] next_mask;
  logic [4:0] pulse_cnt;
  logic [4:0] next_pulse_cnt;
  logic clear_req;
  logic next_clear_req;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_rst_pin_n;
  logic next_guard_timeout_irq;
  logic next_irq;
  logic access;
  logic wr;
  logic mapped;
  logic tmo_event;
  // ****************************************
  // Counter control.
  // ****************************************
  assign wif.hold = low_power_hold || state == WDG_RESET;
  assign wif.clear = clear_req;
  assign wif.reinit = state == WDG_RESET;
  assign wif.per = detection_period_select;
  // ****************************************
  // Next-state logic.
  // ****************************************
  always_comb begin
    access = psel && penable && pready;
    wr = access && pwrite;
    mapped = paddr == ADDR_CFG || paddr == ADDR_CLR || paddr == ADDR_STAT ||
      paddr == ADDR_MASK || paddr == ADDR_CNT;
    tmo_event = wif.ovf && state == WDG_RUN;
    next_state = state;
    next_timeout_action_select = timeout_action_select;
    next_sel_locked = sel_locked;
    next_detection_period_select = detection_period_select;
    next_stat = stat;
    next_mask = mask;
    next_pulse_cnt = pulse_cnt;
    next_clear_req = 1'b0;
    next_guard_timeout_irq = 1'b0;
    next_pready = psel && !penable && !pready;
    next_pslverr = psel && !penable && !mapped;
    next_prdata = '0;
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CFG: begin
          next_prdata[CFG_SEL_BIT] = timeout_action_select;
          next_prdata[CFG_PER_HI:CFG_PER_LO] = detection_period_select;
          next_prdata[CFG_LOCK_BIT] = sel_locked;
        end
        ADDR_STAT: next_prdata[1:0] = stat;
        ADDR_MASK: next_prdata[1:0] = mask;
        ADDR_CNT: next_prdata[BIN_W-1:0] = wif.count;
        default: next_prdata = '0;
      endcase
    end
    if (wr && paddr == ADDR_CFG) begin
      next_detection_period_select = pwdata[CFG_PER_HI:CFG_PER_LO];
      if (!sel_locked) begin
        next_timeout_action_select = pwdata[CFG_SEL_BIT];
        next_sel_locked = 1'b1;
      end
    end
    if (wr && paddr == ADDR_CLR && pwdata[7:0] == CLEAR_CODE) begin
      next_clear_req = 1'b1;
    end
    if (wr && paddr == ADDR_MASK) begin
      next_mask = pwdata[1:0];
    end
    if (wr && paddr == ADDR_STAT) begin
      next_stat = stat & ~pwdata[1:0];
    end
    unique case (state)
      WDG_RUN: begin
        if (tmo_event && timeout_action_select) begin
          next_state = WDG_RESET;
          next_pulse_cnt = RST_PULSE;
        end else if (tmo_event) begin
          next_stat[STAT_TMO_BIT] = 1'b1;
          next_guard_timeout_irq = 1'b1;
        end
      end
      WDG_RESET: begin
        next_timeout_action_select = SEL_RST;
        next_sel_locked = 1'b0;
        next_detection_period_select = PER_RST;
        next_stat = '0;
        next_mask = MASK_RST;
        next_pulse_cnt = pulse_cnt - 1'b1;
        if (pulse_cnt == 5'h01) begin
          next_state = WDG_RUN;
        end
      end
    endcase
    next_rst_pin_n = next_state != WDG_RESET;
    next_irq = |(next_stat & next_mask);
  end
  // ****************************************
  // State registers.
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= WDG_RUN;
      timeout_action_select <= SEL_RST;
      sel_locked <= 1'b0;
      detection_period_select <= PER_RST;
      stat <= '0;
      mask <= MASK_RST;
      pulse_cnt <= '0;
      clear_req <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rst_pin_n <= 1'b1;
      guard_timeout_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      timeout_action_select <= next_timeout_action_select;
      sel_locked <= next_sel_locked;
      detection_period_select <= next_detection_period_select;
      stat <= next_stat;
      mask <= next_mask;
      pulse_cnt <= next_pulse_cnt;
      clear_req <= next_clear_req;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      rst_pin_n <= next_rst_pin_n;
      guard_timeout_irq <= next_guard_timeout_irq;
      irq <= next_irq;
    end
  end
  // ****************************************
  // Checks.
  // ****************************************
  property p_lock;
    @(posedge pclk) disable iff (!presetn)
      (sel_locked && state == WDG_RUN && !wif.ovf) |=> $stable(timeout_action_select);
  endproperty
  a_lock: assert property (p_lock) else $error("locked selector changed");
  property p_default;
    @(posedge pclk) disable iff (!presetn)
      state == WDG_RESET |=> timeout_action_select == SEL_RST && !sel_locked;
  endproperty
  a_default: assert property (p_default) else $error("selector not restored");
  property p_reset_pin;
    @(posedge pclk) disable iff (!presetn)
      (wif.ovf && state == WDG_RUN && timeout_action_select) |=> !rst_pin_n [*8];
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin not driven low");
  property p_int;
    @(posedge pclk) disable iff (!presetn)
      (wif.ovf && state == WDG_RUN && !timeout_action_select) |=>
        stat[STAT_TMO_BIT] && guard_timeout_irq && rst_pin_n;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not raised");
  property p_irq;
    @(posedge pclk) disable iff (!presetn) irq == |(stat & mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_clr_code;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADDR_CLR && pwdata[7:0] == CLEAR_CODE) |=> clear_req;
  endproperty
  a_clr_code: assert property (p_clr_code) else $error("clear code ignored");
  // ****************************************
  // Checks on selector, period, pin, status and counter.
  // ****************************************
  property p_lock_set;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADDR_CFG && state == WDG_RUN) |=> sel_locked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("selector not locked by write");
  property p_lock_keep;
    @(posedge pclk) disable iff (!presetn)
      (sel_locked && state == WDG_RUN) |=> sel_locked;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("selector lock dropped");
  property p_sel_ignored;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADDR_CFG && sel_locked && state == WDG_RUN) |=> $stable(timeout_action_select);
  endproperty
  a_sel_ignored: assert property (p_sel_ignored) else $error("late selector write took");
  property p_rise_default;
    @(posedge pclk) disable iff (!presetn)
      $rose(rst_pin_n) |-> timeout_action_select == SEL_RST && !sel_locked;
  endproperty
  a_rise_default: assert property (p_rise_default) else $error("selector not default");
  property p_per_default;
    @(posedge pclk) disable iff (!presetn)
      $rose(rst_pin_n) |-> detection_period_select == PER_RST;
  endproperty
  a_per_default: assert property (p_per_default) else $error("period not default");
  property p_per_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADDR_CFG && state == WDG_RUN) |=>
        detection_period_select == $past(pwdata[CFG_PER_HI:CFG_PER_LO]);
  endproperty
  a_per_write: assert property (p_per_write) else $error("period write lost");
  property p_pin_start;
    @(posedge pclk) disable iff (!presetn)
      $fell(rst_pin_n) |-> pulse_cnt == RST_PULSE && state == WDG_RESET;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("reset pulse length not loaded");
  property p_pin_end;
    @(posedge pclk) disable iff (!presetn)
      (state == WDG_RESET && pulse_cnt == 5'h01) |=> rst_pin_n && state == WDG_RUN;
  endproperty
  a_pin_end: assert property (p_pin_end) else $error("reset pulse did not end");
  property p_pin_only_rst;
    @(posedge pclk) disable iff (!presetn)
      !rst_pin_n |-> state == WDG_RESET;
  endproperty
  a_pin_only_rst: assert property (p_pin_only_rst) else $error("reset pin low while running");
  property p_reinit;
    @(posedge pclk) disable iff (!presetn)
      state == WDG_RESET |=> wif.count == '0;
  endproperty
  a_reinit: assert property (p_reinit) else $error("counter not reinitialised");
  property p_tmo_act;
    @(posedge pclk) disable iff (!presetn)
      tmo_event |=> !rst_pin_n || guard_timeout_irq;
  endproperty
  a_tmo_act: assert property (p_tmo_act) else $error("overflow raised no output");
  property p_irq_pulse;
    @(posedge pclk) disable iff (!presetn)
      guard_timeout_irq |=> !guard_timeout_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("timeout pulse too long");
  property p_irq_stat;
    @(posedge pclk) disable iff (!presetn)
      guard_timeout_irq |-> stat[STAT_TMO_BIT] && rst_pin_n;
  endproperty
  a_irq_stat: assert property (p_irq_stat) else $error("timeout pulse without status");
  property p_stat_w1c;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADDR_STAT && pwdata[STAT_TMO_BIT] && !tmo_event && state == WDG_RUN) |=>
        !stat[STAT_TMO_BIT];
  endproperty
  a_stat_w1c: assert property (p_stat_w1c) else $error("status not cleared by one");
  property p_stat_sticky;
    @(posedge pclk) disable iff (!presetn)
      (stat[STAT_TMO_BIT] && !(wr && paddr == ADDR_STAT) && state == WDG_RUN) |=>
        stat[STAT_TMO_BIT];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      (stat[STAT_TMO_BIT] && mask[STAT_TMO_BIT]) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("unmasked status without irq");
  property p_clr_hits;
    @(posedge pclk) disable iff (!presetn)
      (clear_req && !low_power_hold && state == WDG_RUN) |=> wif.count == '0;
  endproperty
  a_clr_hits: assert property (p_clr_hits) else $error("clear request missed counter");
  property p_hold_top;
    @(posedge pclk) disable iff (!presetn)
      (low_power_hold && state == WDG_RUN) |=> $stable(wif.count);
  endproperty
  a_hold_top: assert property (p_hold_top) else $error("count moved in low power");
endmodule

// ### verif/wdg_sw.sv
`timescale 1ns/1ps
module wdg_sw (
  // Clock.
  input wire logic pclk,
  // APB master side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import wdg_pkg::*;
  // ****************************************
  // Bus cycles.
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask
  // ****************************************
  // Software duties.
  // ****************************************
  task automatic kick();
    wr(ADDR_CLR, {24'h0, CLEAR_CODE});
  endtask
  task automatic setup(input logic [31:0] cfg);
    wr(ADDR_CFG, cfg);
    kick();
  endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  import wdg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic low_power_hold, rst_pin_n, guard_timeout_irq, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_fail = 0;
  int checked = 0;
  int n_tmo = 0;
  int n, t0;
  // ****************************************
  // Design and software model.
  // ****************************************
  wdg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_hold(low_power_hold), .rst_pin_n(rst_pin_n),
    .guard_timeout_irq(guard_timeout_irq), .irq(irq));
  wdg_sw u_sw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (guard_timeout_irq === 1'b1) n_tmo <= n_tmo + 1;
  end
  // ****************************************
  // Helpers.
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wait_ev(input int lim, input logic on_rst);
    n = 0;
    while (n < lim && (on_rst ? rst_pin_n !== 1'b0 : guard_timeout_irq !== 1'b1)) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    final_report();
  end
  // ****************************************
  // Tests.
  // ****************************************
  initial begin
    presetn = 1'b0;
    low_power_hold = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    u_sw.rd(ADDR_CFG, q, e);
    chk(q, 32'h7);
    u_sw.rd(8'h14, q, e);
    chk({31'h0, e}, 32'h1);
    u_sw.setup(32'h1);
    u_sw.rd(ADDR_CFG, q, e);
    chk(q, 32'h9);
    u_sw.wr(ADDR_CFG, 32'h0);
    u_sw.rd(ADDR_CFG, q, e);
    chk(q, 32'h9);
    wait_ev(16500, 1'b1);
    chk(32'(n > 12200 && n <= 16390), 32'h1);
    wait_ev(0, 1'b1);
    while (rst_pin_n === 1'b0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 32'd16);
    u_sw.rd(ADDR_CFG, q, e);
    chk(q, 32'h7);
    u_sw.setup(32'h0);
    u_sw.rd(ADDR_CFG, q, e);
    chk(q, 32'h8);
    u_sw.wr(ADDR_MASK, 32'h1);
    t0 = n_tmo;
    repeat (2) begin
      repeat (10000) @(posedge pclk);
      u_sw.kick();
    end
    chk(n_tmo, t0);
    u_sw.rd(ADDR_CNT, q, e);
    chk(q, 32'h0);
    wait_ev(16500, 1'b0);
    chk(32'(n < 16500), 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    u_sw.wr(ADDR_STAT, 32'h1);
    u_sw.rd(ADDR_STAT, q, e);
    chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
    u_sw.wr(ADDR_MASK, 32'h0);
    u_sw.kick();
    low_power_hold <= 1'b1;
    t0 = n_tmo;
    repeat (17000) @(posedge pclk);
    chk(n_tmo, t0);
    u_sw.rd(ADDR_CNT, q, e);
    chk(q, 32'h0);
    low_power_hold <= 1'b0;
    wait_ev(16500, 1'b0);
    chk(32'(n < 16500), 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    u_sw.rd(ADDR_STAT, q, e);
    chk(q, 32'h1);
    u_sw.wr(ADDR_CFG, 32'h3);
    u_sw.rd(ADDR_CFG, q, e);
    chk(q, 32'ha);
    u_sw.kick();
    repeat (8200) @(posedge pclk);
    u_sw.rd(ADDR_CNT, q, e);
    chk(32'(q <= 32'h1), 32'h1);
    final_report();
  end
endmodule
